// ==== hw/srb_map.svh ====
/*
  Constants of the small RAM block: storage size, port widths, legal word widths and depths.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef SRB_MAP_SVH
`define SRB_MAP_SVH

`define SRB_MEM_BITS 576
`define SRB_DATA_W 18
`define SRB_ADDR_W 9
`define SRB_BASE_W 10
`define SRB_WIDTH_W 5
`define SRB_CNT_W 10
`define SRB_ROW_W 5
`define SRB_ROW_BITS 18
`define SRB_WIDTH_1 5'h01
`define SRB_WIDTH_2 5'h02
`define SRB_WIDTH_4 5'h04
`define SRB_WIDTH_8 5'h08
`define SRB_WIDTH_9 5'h09
`define SRB_WIDTH_16 5'h10
`define SRB_WIDTH_18 5'h12
`define SRB_DEPTH_512 10'h200
`define SRB_DEPTH_256 10'h100
`define SRB_DEPTH_128 10'h080
`define SRB_DEPTH_64 10'h040
`define SRB_DEPTH_32 10'h020
`define SRB_LANE_HI_16 5'h08
`define SRB_LANE_HI_18 5'h09

`endif

// ==== hw/srb_pkg.sv ====
/*
  Types and shape arithmetic of the small RAM block.
  Assumes srb_map.svh is on the include path.
*/
`include "srb_map.svh"

package srb_pkg;

  typedef enum logic [2:0] {MODE_DUAL, MODE_SINGLE, MODE_FIFO, MODE_ROM, MODE_SHIFT} srb_mode_t;
  typedef enum logic [2:0] {SH_512X1, SH_256X2, SH_128X4, SH_64X8, SH_64X9, SH_32X16,
                            SH_32X18} srb_shape_t;
  typedef enum logic {CLK_IN, CLK_OUT} srb_clk_sel_t;

  function automatic logic [`SRB_WIDTH_W-1:0] srb_shape_width(input srb_shape_t s);
    unique case (s)
      SH_512X1: return `SRB_WIDTH_1;
      SH_256X2: return `SRB_WIDTH_2;
      SH_128X4: return `SRB_WIDTH_4;
      SH_64X8: return `SRB_WIDTH_8;
      SH_64X9: return `SRB_WIDTH_9;
      SH_32X16: return `SRB_WIDTH_16;
      SH_32X18: return `SRB_WIDTH_18;
      default: return `SRB_WIDTH_1;
    endcase
  endfunction : srb_shape_width

  function automatic logic [`SRB_CNT_W-1:0] srb_shape_depth(input srb_shape_t s);
    unique case (s)
      SH_512X1: return `SRB_DEPTH_512;
      SH_256X2: return `SRB_DEPTH_256;
      SH_128X4: return `SRB_DEPTH_128;
      SH_64X8, SH_64X9: return `SRB_DEPTH_64;
      SH_32X16, SH_32X18: return `SRB_DEPTH_32;
      default: return `SRB_DEPTH_512;
    endcase
  endfunction : srb_shape_depth

  // Address wraps inside the shape's depth, so the bit base never leaves the array
  function automatic logic [`SRB_BASE_W-1:0] srb_bit_base(input logic [`SRB_ADDR_W-1:0] addr,
                                                         input srb_shape_t s);
    logic [`SRB_CNT_W-1:0] lim;
    logic [14:0] prod;
    lim = `SRB_CNT_W'(srb_shape_depth(s) - `SRB_CNT_W'(1));
    prod = 15'(addr & lim[`SRB_ADDR_W-1:0]) * 15'(srb_shape_width(s));
    return prod[`SRB_BASE_W-1:0];
  endfunction : srb_bit_base

endpackage : srb_pkg

// ==== hw/srb_mem_if.sv ====
/*
  Interface between the small RAM block control logic and its bit array.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`include "srb_map.svh"

interface srb_mem_if;
  logic we;
  logic [`SRB_BASE_W-1:0] wr_base;
  logic [`SRB_WIDTH_W-1:0] wr_width;
  logic [`SRB_DATA_W-1:0] wr_mask;
  logic [`SRB_DATA_W-1:0] wr_data;
  logic [`SRB_BASE_W-1:0] rd_base;
  logic [`SRB_WIDTH_W-1:0] rd_width;
  logic [`SRB_DATA_W-1:0] rd_data;

  modport ctrl (output we, wr_base, wr_width, wr_mask, wr_data, rd_base, rd_width,
                input rd_data);
  modport store (input we, wr_base, wr_width, wr_mask, wr_data, rd_base, rd_width,
                 output rd_data);
endinterface : srb_mem_if

// ==== hw/srb_store.sv ====
/*
  The 576-bit array of the small RAM block, bit addressed so that any shape fits.
  Assumes the control side keeps base plus width inside the array.
*/
`timescale 1ns/1ps
`include "srb_map.svh"

module srb_store
  import srb_pkg::*;
(
  // Clock
  input wire logic clk,
  // Array port
  srb_mem_if.store m
);

  // Contents are never reset; only the output side clears
  logic [`SRB_MEM_BITS-1:0] mem_q;

  always_ff @(posedge clk)
  begin
    for (int i = 0; i < `SRB_DATA_W; i++)
    begin
      if (m.we && (`SRB_WIDTH_W'(i) < m.wr_width) && m.wr_mask[i])
      begin
        mem_q[`SRB_BASE_W'(m.wr_base + `SRB_BASE_W'(i))] <= m.wr_data[i];
      end
    end
  end

  always_comb
  begin
    m.rd_data = '0;
    for (int i = 0; i < `SRB_DATA_W; i++)
    begin
      if (`SRB_WIDTH_W'(i) < m.rd_width)
      begin
        m.rd_data[i] = mem_q[`SRB_BASE_W'(m.rd_base + `SRB_BASE_W'(i))];
      end
    end
  end

  a_idle_keeps_mem: assert property (@(posedge clk) !m.we |=> $stable(mem_q))
    else $error("array changed without a write");

endmodule : srb_store

// ==== hw/srb_small_ram_block.sv ====
/*
  Small RAM block: 576-bit simple dual-port memory with RAM, ROM, FIFO and shift modes.
  Assumes the two block clocks reach it as one-cycle enables on clk from surrounding logic.
*/
`timescale 1ns/1ps
`include "srb_map.svh"

module srb_small_ram_block
  import srb_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // The two block clocks as enables
  input wire logic in_ce,
  input wire logic out_ce,
  // Configuration
  input wire srb_mode_t mode,
  input wire srb_shape_t wr_shape,
  input wire srb_shape_t rd_shape,
  input wire srb_clk_sel_t wr_clk_sel,
  input wire srb_clk_sel_t rd_addr_clk_sel,
  input wire srb_clk_sel_t rd_en_clk_sel,
  input wire srb_clk_sel_t out_clk_sel,
  input wire logic out_bypass,
  // Image preload
  input wire logic init_wr,
  input wire logic [`SRB_ROW_W-1:0] init_row,
  input wire logic [`SRB_DATA_W-1:0] init_data,
  // Write port
  input wire logic wr_en,
  input wire logic [`SRB_ADDR_W-1:0] wr_addr,
  input wire logic [`SRB_DATA_W-1:0] wr_data,
  input wire logic [1:0] wr_byte_en,
  // Read port
  input wire logic rd_en,
  input wire logic [`SRB_ADDR_W-1:0] rd_addr,
  input wire logic out_clr,
  output logic [`SRB_DATA_W-1:0] rd_data,
  // FIFO status
  output logic fifo_full,
  output logic fifo_empty
);

  srb_mem_if m ();

  srb_store u_store (
    .clk(clk),
    .m(m)
  );

  logic wce, race, rece, oce;
  logic commit_q;
  logic [`SRB_ADDR_W-1:0] wr_addr_q, rd_addr_q, wp_q, rp_q;
  logic [`SRB_DATA_W-1:0] wr_data_q, out_q, rd_data_q;
  logic [1:0] wr_be_q;
  logic rd_en_q;
  logic [`SRB_CNT_W-1:0] count_q, count_d, depth;
  logic push, pop, full_q, empty_q;
  srb_shape_t rd_eff_shape;
  logic [`SRB_ADDR_W-1:0] wr_sel_addr, rd_sel_addr;
  logic rd_en_eff, writable;
  logic [`SRB_DATA_W-1:0] lane_mask;
  logic [`SRB_WIDTH_W-1:0] lane_split;

  assign wce = (wr_clk_sel == CLK_OUT) ? out_ce : in_ce;
  assign race = (rd_addr_clk_sel == CLK_OUT) ? out_ce : in_ce;
  assign rece = (rd_en_clk_sel == CLK_OUT) ? out_ce : in_ce;
  assign oce = (out_clk_sel == CLK_OUT) ? out_ce : in_ce;

  assign depth = srb_shape_depth(wr_shape);
  assign push = (mode == MODE_FIFO) && wce && wr_en && !full_q;
  assign pop = (mode == MODE_FIFO) && rece && rd_en && !empty_q;

  // The dual-port and ROM modes keep a separate read width; the others mirror the write side
  always_comb
  begin
    rd_eff_shape = wr_shape;
    wr_sel_addr = wr_addr;
    rd_sel_addr = rd_addr;
    rd_en_eff = rd_en;
    writable = 1'b1;
    unique case (mode)
      MODE_DUAL: rd_eff_shape = rd_shape;
      MODE_SINGLE: rd_sel_addr = wr_addr;
      MODE_FIFO:
      begin
        wr_sel_addr = wp_q;
        rd_sel_addr = rp_q;
        rd_en_eff = pop;
        writable = !full_q;
      end
      MODE_ROM:
      begin
        rd_eff_shape = rd_shape;
        writable = 1'b0;
      end
      MODE_SHIFT:
      begin
        wr_sel_addr = wp_q;
        rd_sel_addr = wp_q;
        rd_en_eff = wr_en;
      end
      default: writable = 1'b0;
    endcase
  end

  // Byte lanes: parity bit rides with its byte, so the split is 8 or 9
  always_comb
  begin
    lane_split = (wr_shape == SH_32X18) ? `SRB_LANE_HI_18 : `SRB_LANE_HI_16;
    lane_mask = '0;
    for (int i = 0; i < `SRB_DATA_W; i++)
    begin
      if ((wr_shape == SH_32X16 || wr_shape == SH_32X18) && `SRB_WIDTH_W'(i) >= lane_split)
      begin
        lane_mask[i] = wr_be_q[1];
      end
      else
      begin
        lane_mask[i] = wr_be_q[0];
      end
    end
  end

  // Write input registers: always in the path, all on one enable
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      commit_q <= 1'b0;
      wr_addr_q <= '0;
      wr_data_q <= '0;
      wr_be_q <= '0;
    end
    else
    begin
      commit_q <= wce && wr_en && writable;
      if (wce)
      begin
        wr_addr_q <= wr_sel_addr;
        wr_data_q <= wr_data;
        wr_be_q <= wr_byte_en;
      end
    end
  end

  // Array port; preload takes precedence and writes whole 18-bit rows
  always_comb
  begin
    m.we = commit_q || init_wr;
    m.wr_base = srb_bit_base(wr_addr_q, wr_shape);
    m.wr_width = srb_shape_width(wr_shape);
    m.wr_mask = lane_mask;
    m.wr_data = wr_data_q;
    if (init_wr)
    begin
      m.wr_base = srb_bit_base(`SRB_ADDR_W'(init_row), SH_32X18);
      m.wr_width = `SRB_WIDTH_18;
      m.wr_mask = '1;
      m.wr_data = init_data;
    end
    m.rd_base = srb_bit_base(rd_addr_q, rd_eff_shape);
    m.rd_width = srb_shape_width(rd_eff_shape);
  end

  // FIFO and shift pointers
  always_comb
  begin
    count_d = count_q;
    if (push && !pop)
    begin
      count_d = `SRB_CNT_W'(count_q + `SRB_CNT_W'(1));
    end
    else if (pop && !push)
    begin
      count_d = `SRB_CNT_W'(count_q - `SRB_CNT_W'(1));
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst || (mode != MODE_FIFO && mode != MODE_SHIFT))
    begin
      wp_q <= '0;
      rp_q <= '0;
      count_q <= '0;
      full_q <= 1'b0;
      empty_q <= 1'b1;
    end
    else
    begin
      if (push || (mode == MODE_SHIFT && wce && wr_en))
      begin
        wp_q <= (`SRB_CNT_W'(wp_q) == `SRB_CNT_W'(depth - `SRB_CNT_W'(1))) ? '0
                : `SRB_ADDR_W'(wp_q + `SRB_ADDR_W'(1));
      end
      if (pop)
      begin
        rp_q <= (`SRB_CNT_W'(rp_q) == `SRB_CNT_W'(depth - `SRB_CNT_W'(1))) ? '0
                : `SRB_ADDR_W'(rp_q + `SRB_ADDR_W'(1));
      end
      count_q <= count_d;
      full_q <= (mode == MODE_FIFO) && (count_d == depth);
      empty_q <= (count_d == '0);
    end
  end

  // Read input registers; the address moves only while reading so data holds
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rd_addr_q <= '0;
      rd_en_q <= 1'b0;
    end
    else
    begin
      if (race && rd_en_eff)
      begin
        rd_addr_q <= rd_sel_addr;
      end
      if (rece)
      begin
        rd_en_q <= rd_en_eff;
      end
    end
  end

  // The array is sampled a cycle after the write input stage, so a colliding read sees old data
  always_ff @(posedge clk)
  begin
    if (rst || out_clr)
    begin
      out_q <= '0;
    end
    else if (oce && rd_en_q)
    begin
      out_q <= m.rd_data;
    end
  end

  // Bypass still ends in a flop so the pin timing stays fixed
  always_ff @(posedge clk)
  begin
    if (rst || out_clr)
    begin
      rd_data_q <= '0;
    end
    else if (out_bypass)
    begin
      if (rd_en_q)
      begin
        rd_data_q <= m.rd_data;
      end
    end
    else
    begin
      rd_data_q <= out_q;
    end
  end

  assign rd_data = rd_data_q;
  assign fifo_full = full_q;
  assign fifo_empty = empty_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_write_req;
    wce && wr_en && writable && !init_wr;
  endsequence

  sequence s_commit;
    ##1 commit_q;
  endsequence

  a_write_commit: assert property (s_write_req |-> s_commit)
    else $error("accepted write did not commit");
  a_rom_no_write: assert property (mode == MODE_ROM |=> !commit_q)
    else $error("write committed in ROM mode");
  a_clear_zeroes: assert property (out_clr |=> rd_data == '0)
    else $error("output clear did not zero read data");
  a_reset_zeroes: assert property (disable iff (1'b0) rst |=> rd_data == '0 && out_q == '0)
    else $error("reset did not zero outputs");
  a_read_holds: assert property (!out_bypass && !rd_en_q && !out_clr ##1 !out_bypass && !out_clr
                                 |=> $stable(rd_data))
    else $error("read data moved without read enable");
  a_bypass_path: assert property (out_bypass && rd_en_q && !out_clr
                                  |=> rd_data == $past(m.rd_data))
    else $error("bypass did not present array data");
  a_fifo_flags: assert property (!(full_q && empty_q) && count_q <= depth)
    else $error("fifo flags inconsistent");
  a_reg_latency: assert property (!out_bypass && oce && rd_en_q && !out_clr ##1 !out_bypass
                                  && !out_clr |=> rd_data == $past(m.rd_data, 2))
    else $error("registered read latency wrong");

endmodule : srb_small_ram_block

// ==== tb/srb_fabric_model.sv ====
/*
  Fabric model: makes the two block clocks as enables on clk.
  Assumes the bench raises hold_out to stop the output clock.
*/
`timescale 1ns/1ps
module srb_fabric_model (
  // Clock
  input wire logic clk,
  // Control
  input wire logic hold_out,
  // Block clocks
  output logic in_ce,
  output logic out_ce
);
  // Input clock never stops, so write timing stays fixed
  always_ff @(posedge clk)
  begin
    in_ce <= 1'b1;
    out_ce <= !hold_out;
  end
endmodule : srb_fabric_model

// ==== tb/tb_top.sv ====
/*
  Self-checking bench of the small RAM block.
  Assumes the design files and srb_map.svh are compiled first.
*/
`timescale 1ns/1ps
module tb_top
  import srb_pkg::*;
;
  logic clk = 0, rst = 1, in_ce, out_ce, hold_out = 0;
  srb_mode_t mode = MODE_DUAL;
  srb_shape_t wr_shape = SH_32X18, rd_shape = SH_32X18;
  srb_clk_sel_t wr_sel = CLK_IN, rsel = CLK_IN, osel = CLK_IN;
  logic out_bypass = 0, init_wr = 0, wr_en = 0, rd_en = 0, out_clr = 0;
  logic [4:0] init_row = 5'h00;
  logic [17:0] init_data = 18'h00000, wr_data = 18'h00000, rd_data, d;
  logic [8:0] wr_addr = 9'h000, rd_addr = 9'h000;
  logic [1:0] wr_byte_en = 2'h3;
  logic fifo_full, fifo_empty;
  logic [575:0] mem_m;
  logic [17:0] exp_q[$], fq[$];
  logic [2:0] pipe = 3'h0;
  int errors = 0, checks_done = 0, a, r;
  int wid[7] = '{1, 2, 4, 8, 9, 16, 18};
  int dep[7] = '{512, 256, 128, 64, 64, 32, 32};

  always #2 clk = ~clk;

  srb_fabric_model u_fab (.clk(clk), .hold_out(hold_out), .in_ce(in_ce), .out_ce(out_ce));

  srb_small_ram_block u_dut (.clk(clk), .rst(rst), .in_ce(in_ce), .out_ce(out_ce),
    .mode(mode), .wr_shape(wr_shape), .rd_shape(rd_shape), .wr_clk_sel(wr_sel),
    .rd_addr_clk_sel(rsel), .rd_en_clk_sel(rsel), .out_clk_sel(osel),
    .out_bypass(out_bypass), .init_wr(init_wr), .init_row(init_row),
    .init_data(init_data), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .wr_byte_en(wr_byte_en), .rd_en(rd_en), .rd_addr(rd_addr), .out_clr(out_clr),
    .rd_data(rd_data), .fifo_full(fifo_full), .fifo_empty(fifo_empty));

  task automatic chk(string nm, logic [17:0] e, logic [17:0] s);
    checks_done++;
    if (s !== e)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  function automatic logic [17:0] rd_m(int ad, int sh);
    logic [17:0] v;
    v = 18'h00000;
    for (int i = 0; i < wid[sh]; i++)
      v[i] = mem_m[(ad % dep[sh]) * wid[sh] + i];
    return v;
  endfunction : rd_m

  task automatic idle(int n);
    wr_en <= 0;
    rd_en <= 0;
    repeat (n) @(posedge clk);
  endtask : idle

  // Model follows only writes the block must take; lanes split in half for 16 and 18
  task automatic wr(int ad, logic [17:0] v, logic [1:0] be, bit take);
    int w, b;
    w = wid[wr_shape];
    b = (ad % dep[wr_shape]) * w;
    wr_en <= 1;
    wr_addr <= 9'(ad);
    wr_data <= v;
    wr_byte_en <= be;
    @(posedge clk);
    for (int i = 0; i < w; i++)
      if (take && (w >= 16 ? be[i >= w / 2] : be[0]))
        mem_m[b + i] = v[i];
  endtask : wr

  task automatic rd_x(int ad, logic [17:0] e);
    exp_q.push_back(e);
    rd_en <= 1;
    rd_addr <= 9'(ad);
    // Single-port mode reads at the write address, so both follow the read
    wr_addr <= 9'(ad);
    @(posedge clk);
  endtask : rd_x

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  // Result appears three edges after the read is taken, two when bypassed
  always @(posedge clk)
  begin
    if (out_bypass ? pipe[1] : pipe[2])
    begin
      if (exp_q.size() == 0)
        chk("spare read", 18'h00000, 18'h3FFFF);
      else
        chk("rd_data", exp_q.pop_front(), rd_data);
    end
    pipe <= {pipe[1:0], rd_en && !rst};
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    errors++;
    $display("watchdog expired");
    conclude();
  end

  initial
  begin
    void'($urandom(87480));
    repeat (6) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    #1;
    chk("rd_data", 18'h00000, rd_data);
    chk("fifo_empty", 18'h00001, 18'(fifo_empty));
    chk("fifo_full", 18'h00000, 18'(fifo_full));
    @(posedge clk);
    for (int i = 0; i < 32; i++)
    begin
      d = 18'($urandom);
      mem_m[i * 18 +: 18] = d;
      init_wr <= 1;
      init_row <= 5'(i);
      init_data <= d;
      @(posedge clk);
    end
    init_wr <= 0;
    idle(2);
    for (int i = 0; i < 32; i++)
      rd_x(i, rd_m(i, 6));
    idle(6);
    $display("test preload done");
    for (int s = 0; s < 7; s++)
    begin
      mode <= s % 2 ? MODE_SINGLE : MODE_DUAL;
      r = s % 2 ? s : (s + 3) % 7;
      wr_shape <= srb_shape_t'(s);
      rd_shape <= srb_shape_t'(r);
      idle(1);
      for (int k = 0; k < 4; k++)
        wr($urandom_range(dep[s] - 1), 18'($urandom), 2'($urandom), 1);
      idle(2);
      for (int k = 0; k < 6; k++)
        rd_x(k * 37, rd_m(k * 37, r));
      idle(6);
    end
    $display("test shapes done");
    mode <= MODE_DUAL;
    wr_shape <= SH_32X18;
    rd_shape <= SH_32X18;
    idle(1);
    d = rd_m(5, 6);
    // Read taken on the same edge as the write to that address sees the old word
    exp_q.push_back(d);
    rd_en <= 1;
    rd_addr <= 9'h005;
    wr(5, ~d, 2'h3, 1);
    idle(2);
    rd_x(5, ~d);
    idle(6);
    mode <= MODE_ROM;
    idle(1);
    wr(7, 18'h2A5A5, 2'h3, 0);
    idle(2);
    rd_x(7, rd_m(7, 6));
    mode <= MODE_DUAL;
    wr_sel <= CLK_OUT;
    hold_out <= 1;
    idle(3);
    wr(9, 18'h15A5A, 2'h3, 0);
    hold_out <= 0;
    idle(3);
    wr_sel <= CLK_IN;
    rd_x(9, rd_m(9, 6));
    idle(6);
    $display("test refusals done");
    rd_addr <= 9'h00B;
    idle(6);
    chk("held rd_data", rd_m(9, 6), rd_data);
    // Stopped output clock: a read on either register side must leave the output alone
    hold_out <= 1;
    for (int p = 0; p < 2; p++)
    begin
      rsel <= p ? CLK_IN : CLK_OUT;
      osel <= p ? CLK_OUT : CLK_IN;
      idle(2);
      rd_x(3, rd_m(9, 6));
      idle(6);
    end
    hold_out <= 0;
    rsel <= CLK_IN;
    osel <= CLK_IN;
    out_clr <= 1;
    @(posedge clk);
    out_clr <= 0;
    @(posedge clk);
    #1;
    chk("cleared rd_data", 18'h00000, rd_data);
    @(posedge clk);
    out_bypass <= 1;
    idle(1);
    for (int k = 0; k < 8; k++)
      rd_x(k * 3, rd_m(k * 3, 6));
    idle(6);
    out_bypass <= 0;
    $display("test output done");
    // Shift mode hands back the word that stood in each slot before it was written
    mode <= MODE_SHIFT;
    idle(2);
    for (int k = 0; k < 8; k++)
    begin
      d = 18'($urandom);
      exp_q.push_back(rd_m(k, 6));
      rd_en <= 1;
      wr(k, d, 2'h3, 1);
    end
    idle(6);
    mode <= MODE_DUAL;
    $display("test shift done");
    idle(1);
    mode <= MODE_FIFO;
    idle(2);
    for (int k = 0; k < 32; k++)
    begin
      d = 18'($urandom);
      fq.push_back(d);
      wr(0, d, 2'h3, 0);
    end
    idle(2);
    chk("fifo_full", 18'h00001, 18'(fifo_full));
    for (int k = 0; k < 32; k++)
      rd_x(0, fq.pop_front());
    idle(6);
    chk("fifo_empty", 18'h00001, 18'(fifo_empty));
    chk("pending reads", 18'h00000, 18'(exp_q.size()));
    $display("test fifo done");
    conclude();
  end
endmodule : tb_top
